//--- pmcr_consts.svh
/*
 * offsets, field positions, reset values and identification codes of the
 * configuration and status register bank.
 * assumes it is included by its bare name wherever these constants are used.
 */
`ifndef PMCR_CONSTS_SVH
`define PMCR_CONSTS_SVH

// register offsets within the i/o register space
`define PMCR_OFF_IN_CELL_A     8'h0a
`define PMCR_OFF_IN_CELL_B     8'h0b
`define PMCR_OFF_IN_CELL_D     8'h1a
`define PMCR_OFF_OUT_CELL_A    8'h20
`define PMCR_OFF_OUT_CELL_B    8'h21
`define PMCR_OFF_MASK_A        8'h22
`define PMCR_OFF_MASK_B        8'h23
`define PMCR_OFF_POWER_0       8'hb0
`define PMCR_OFF_POWER_2       8'hb4
`define PMCR_OFF_PRIM_PROT     8'hc0
`define PMCR_OFF_BOOT_PROT     8'hc2
`define PMCR_OFF_TEST_EN       8'hc7
`define PMCR_OFF_PAGE          8'he0
`define PMCR_OFF_SPACE_MAP     8'he2
`define PMCR_OFF_MEM_ID0       8'hf0
`define PMCR_OFF_MEM_ID1       8'hf1

// power mode control 0 fields
`define PMCR_P0_AUTO_PD        1
`define PMCR_P0_FAST_OFF       3
`define PMCR_P0_ARRAY_CLK      4
`define PMCR_P0_CELL_CLK       5
`define PMCR_P0_USED_MASK      8'h3a

// power mode control 2 fields
`define PMCR_P2_ADDR           0
`define PMCR_P2_CTRL0          2
`define PMCR_P2_CTRL1          3
`define PMCR_P2_CTRL2          4
`define PMCR_P2_ALE            5
`define PMCR_P2_HIGH_WR        6
`define PMCR_P2_USED_MASK      8'h7d

// memory space map fields
`define PMCR_MAP_SRAM_CODE     0
`define PMCR_MAP_SEC_CODE      1
`define PMCR_MAP_PRIM_CODE     2
`define PMCR_MAP_SEC_DATA      3
`define PMCR_MAP_PRIM_DATA     4
`define PMCR_MAP_PERIPH        7
`define PMCR_MAP_USED_MASK     8'h9f

// boot protection fields
`define PMCR_BOOT_SEC_BIT      7

// test port enable field
`define PMCR_TEST_EN_BIT       0

// reset values
`define PMCR_RST_BYTE          8'h00
`define PMCR_RST_PAGE          8'h00

// identification codes
`define PMCR_PRIM_4MBIT        4'h4
`define PMCR_PRIM_8MBIT        4'h5
`define PMCR_SRAM_NONE         4'h0
`define PMCR_SRAM_16KBIT       4'h1
`define PMCR_SRAM_64KBIT       4'h3
`define PMCR_SEC_NONE          4'h0
`define PMCR_SEC_256KBIT       4'h2
`define PMCR_SEC_IS_FLASH      2'h0
`define PMCR_SEC_IS_EEPROM     2'h1

`endif

//--- pmcr_pkg.sv
/*
 * types shared by the configuration and status register bank.
 * assumes nothing of its surroundings.
 */
package pmcr_pkg;
	typedef logic [7:0] pmcr_byte_t;
	typedef logic [3:0] pmcr_size_code_t;
	typedef logic [1:0] pmcr_type_code_t;
endpackage

//--- pmcr_regs.sv
/*
 * configuration and status register bank: macrocell read-back and load,
 * flash protection status, test port enable, page register, power
 * management gating and memory space map with identification registers.
 * assumes a synchronous single-cycle register strobe from the mcu bus
 * decoder and that all inputs are synchronous to CLK.
 */
`timescale 1ns/1ps
`include "pmcr_consts.svh"

module pmcr_regs
	import pmcr_pkg::*;
#(
	parameter pmcr_size_code_t PRIM_SIZE = `PMCR_PRIM_4MBIT,
	parameter pmcr_size_code_t SRAM_SIZE = `PMCR_SRAM_64KBIT,
	parameter pmcr_size_code_t SEC_SIZE  = `PMCR_SEC_256KBIT,
	parameter pmcr_type_code_t SEC_TYPE  = `PMCR_SEC_IS_FLASH
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       POWER_ON_RST_N,
	input  wire logic       REG_SEL,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic [7:0] INPUT_CELL_BITS,
	input  wire logic [7:0] PRIM_SECTOR_PROT,
	input  wire logic [3:0] SEC_SECTOR_PROT,
	input  wire logic       SECURITY_SET,
	input  wire logic [4:1] CFG_SPACE_MAP,
	input  wire logic       MODE_8051,
	input  wire logic       MODE_ALT_BUS,
	input  wire logic       LOGIC_CLOCK_INPUT,
	input  wire logic [7:0] ADDR_LOW,
	input  wire logic [3:0] PORT_F_LOW,
	input  wire logic [7:4] BUS_HIGH,
	input  wire logic       CONTROL_INPUT_ZERO,
	input  wire logic       CONTROL_INPUT_ONE,
	input  wire logic       CONTROL_INPUT_TWO,
	input  wire logic       ALE_INPUT,
	input  wire logic       HIGH_WRITE_BYTE_ENABLE,
	output logic      [7:0] OUTPUT_CELL_GROUP_A_BITS,
	output logic      [7:0] OUTPUT_CELL_GROUP_B_BITS,
	output logic      [7:0] PAGE_BITS,
	output logic            TEST_PORT_ENABLED,
	output logic            AUTO_POWER_DOWN,
	output logic            ARRAY_FAST_MODE,
	output logic            ARRAY_CLOCK,
	output logic            ARRAY_WAKE,
	output logic            CELL_CLOCK,
	output logic      [7:0] ARRAY_ADDR,
	output logic            ARRAY_CONTROL_ZERO,
	output logic            ARRAY_CONTROL_ONE,
	output logic            ARRAY_CONTROL_TWO,
	output logic            ARRAY_ALE,
	output logic            ARRAY_HIGH_WRITE,
	output logic            SRAM_IN_PROGRAM_SPACE,
	output logic            SECONDARY_IN_PROGRAM_SPACE,
	output logic            PRIMARY_IN_PROGRAM_SPACE,
	output logic            SECONDARY_IN_DATA_SPACE,
	output logic            PRIMARY_IN_DATA_SPACE,
	output logic            PORT_F_PERIPHERAL_MODE
);

	pmcr_byte_t cell_a_reg;
	pmcr_byte_t cell_b_reg;
	pmcr_byte_t mask_a_reg;
	pmcr_byte_t mask_b_reg;
	pmcr_byte_t page_reg;
	pmcr_byte_t power_0_reg;
	pmcr_byte_t power_2_reg;
	pmcr_byte_t space_map_reg;
	logic       test_en_reg;
	logic       map_load_reg;
	logic       clk_in_reg;
	logic       clk_in_seen_reg;
	logic       wake_reg;
	pmcr_byte_t rdata_reg;
	pmcr_byte_t rdata_next;
	logic       wr_hit;
	logic       rd_hit;

	assign wr_hit = REG_SEL & REG_WR;
	assign rd_hit = REG_SEL & REG_RD;

	// output macrocells, masked bits keep their value
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cell_a_reg <= `PMCR_RST_BYTE;
			cell_b_reg <= `PMCR_RST_BYTE;
		end else if (wr_hit) begin
			if (REG_ADDR == `PMCR_OFF_OUT_CELL_A) begin
				cell_a_reg <= (REG_WDATA & ~mask_a_reg) | (cell_a_reg & mask_a_reg);
			end
			if (REG_ADDR == `PMCR_OFF_OUT_CELL_B) begin
				cell_b_reg <= (REG_WDATA & ~mask_b_reg) | (cell_b_reg & mask_b_reg);
			end
		end
	end

	// write masks
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_a_reg <= `PMCR_RST_BYTE;
			mask_b_reg <= `PMCR_RST_BYTE;
		end else if (wr_hit) begin
			if (REG_ADDR == `PMCR_OFF_MASK_A) begin
				mask_a_reg <= REG_WDATA;
			end
			if (REG_ADDR == `PMCR_OFF_MASK_B) begin
				mask_b_reg <= REG_WDATA;
			end
		end
	end

	// page and test port enable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			page_reg    <= `PMCR_RST_PAGE;
			test_en_reg <= 1'b0;
		end else if (wr_hit) begin
			if (REG_ADDR == `PMCR_OFF_PAGE) begin
				page_reg <= REG_WDATA;
			end
			if (REG_ADDR == `PMCR_OFF_TEST_EN) begin
				test_en_reg <= REG_WDATA[`PMCR_TEST_EN_BIT];
			end
		end
	end

	// power registers survive the ordinary reset
	always_ff @(posedge CLK or negedge POWER_ON_RST_N) begin
		if (!POWER_ON_RST_N) begin
			power_0_reg <= `PMCR_RST_BYTE;
			power_2_reg <= `PMCR_RST_BYTE;
		end else if (wr_hit) begin
			if (REG_ADDR == `PMCR_OFF_POWER_0) begin
				power_0_reg <= REG_WDATA & `PMCR_P0_USED_MASK;
			end
			if (REG_ADDR == `PMCR_OFF_POWER_2) begin
				power_2_reg <= REG_WDATA & `PMCR_P2_USED_MASK;
			end
		end
	end

	// space map: cleared by reset, configuration caught after release
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			space_map_reg <= `PMCR_RST_BYTE;
			map_load_reg  <= 1'b1;
		end else if (map_load_reg) begin
			space_map_reg[4:1] <= CFG_SPACE_MAP;
			map_load_reg       <= 1'b0;
		end else if (wr_hit && REG_ADDR == `PMCR_OFF_SPACE_MAP) begin
			space_map_reg <= REG_WDATA & `PMCR_MAP_USED_MASK;
		end
	end

	// clock input change detect for array wake, no false edge after reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			clk_in_reg      <= 1'b0;
			clk_in_seen_reg <= 1'b0;
			wake_reg        <= 1'b0;
		end else begin
			clk_in_reg      <= LOGIC_CLOCK_INPUT;
			clk_in_seen_reg <= 1'b1;
			wake_reg        <= (LOGIC_CLOCK_INPUT ^ clk_in_reg)
				& clk_in_seen_reg
				& ~power_0_reg[`PMCR_P0_ARRAY_CLK]
				& power_0_reg[`PMCR_P0_FAST_OFF];
		end
	end

	// read mux, unmapped and unused bits read zero
	always_comb begin
		rdata_next = 8'h00;
		unique case (REG_ADDR)
			`PMCR_OFF_IN_CELL_A, `PMCR_OFF_IN_CELL_B, `PMCR_OFF_IN_CELL_D: begin
				rdata_next = INPUT_CELL_BITS;
			end
			`PMCR_OFF_OUT_CELL_A: begin
				rdata_next = cell_a_reg;
			end
			`PMCR_OFF_OUT_CELL_B: begin
				rdata_next = cell_b_reg;
			end
			`PMCR_OFF_MASK_A: begin
				rdata_next = mask_a_reg;
			end
			`PMCR_OFF_MASK_B: begin
				rdata_next = mask_b_reg;
			end
			`PMCR_OFF_PRIM_PROT: begin
				rdata_next = PRIM_SECTOR_PROT;
			end
			`PMCR_OFF_BOOT_PROT: begin
				rdata_next = {SECURITY_SET, 3'h0, SEC_SECTOR_PROT};
			end
			`PMCR_OFF_TEST_EN: begin
				rdata_next = {7'h00, test_en_reg};
			end
			`PMCR_OFF_PAGE: begin
				rdata_next = page_reg;
			end
			`PMCR_OFF_POWER_0: begin
				rdata_next = power_0_reg;
			end
			`PMCR_OFF_POWER_2: begin
				rdata_next = power_2_reg;
			end
			`PMCR_OFF_SPACE_MAP: begin
				rdata_next = space_map_reg;
			end
			`PMCR_OFF_MEM_ID0: begin
				rdata_next = {SRAM_SIZE, PRIM_SIZE};
			end
			`PMCR_OFF_MEM_ID1: begin
				rdata_next = {2'h0, SEC_TYPE, SEC_SIZE};
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= 8'h00;
		end else if (rd_hit) begin
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA                = rdata_reg;
	assign OUTPUT_CELL_GROUP_A_BITS = cell_a_reg;
	assign OUTPUT_CELL_GROUP_B_BITS = cell_b_reg;
	assign PAGE_BITS                = page_reg;
	assign TEST_PORT_ENABLED        = test_en_reg;

	// power management gating
	assign AUTO_POWER_DOWN = power_0_reg[`PMCR_P0_AUTO_PD];
	assign ARRAY_FAST_MODE = ~power_0_reg[`PMCR_P0_FAST_OFF];
	assign ARRAY_CLOCK     = LOGIC_CLOCK_INPUT & ~power_0_reg[`PMCR_P0_ARRAY_CLK];
	assign ARRAY_WAKE      = wake_reg;
	assign CELL_CLOCK      = LOGIC_CLOCK_INPUT & ~power_0_reg[`PMCR_P0_CELL_CLK];
	assign ARRAY_ADDR      = power_2_reg[`PMCR_P2_ADDR] ? 8'h00 :
		(MODE_ALT_BUS ? {BUS_HIGH, PORT_F_LOW} : ADDR_LOW);
	assign ARRAY_CONTROL_ZERO = CONTROL_INPUT_ZERO & ~power_2_reg[`PMCR_P2_CTRL0];
	assign ARRAY_CONTROL_ONE  = CONTROL_INPUT_ONE & ~power_2_reg[`PMCR_P2_CTRL1];
	assign ARRAY_CONTROL_TWO  = CONTROL_INPUT_TWO & ~power_2_reg[`PMCR_P2_CTRL2];
	assign ARRAY_ALE          = ALE_INPUT & ~power_2_reg[`PMCR_P2_ALE];
	assign ARRAY_HIGH_WRITE   = HIGH_WRITE_BYTE_ENABLE & ~power_2_reg[`PMCR_P2_HIGH_WR];

	// memory space map, bits 0-4 only in 8051-family mode
	assign SRAM_IN_PROGRAM_SPACE      = MODE_8051 & space_map_reg[`PMCR_MAP_SRAM_CODE];
	assign SECONDARY_IN_PROGRAM_SPACE = MODE_8051 & space_map_reg[`PMCR_MAP_SEC_CODE];
	assign PRIMARY_IN_PROGRAM_SPACE   = MODE_8051 & space_map_reg[`PMCR_MAP_PRIM_CODE];
	assign SECONDARY_IN_DATA_SPACE    = MODE_8051 & space_map_reg[`PMCR_MAP_SEC_DATA];
	assign PRIMARY_IN_DATA_SPACE      = MODE_8051 & space_map_reg[`PMCR_MAP_PRIM_DATA];
	assign PORT_F_PERIPHERAL_MODE     = space_map_reg[`PMCR_MAP_PERIPH];

endmodule

//--- pmcr_mcu_model.sv
/*
 * bus master model of the microcontroller: one write or read per call.
 * assumes the register strobe is taken at the rising edge after it is driven.
 */
`timescale 1ns/1ps
module pmcr_mcu_model (
	input  wire logic       clk,
	output logic            sel,
	output logic            wr,
	output logic            rd,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata
);
	initial begin
		sel = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// write held for one edge, then released
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sel <= 1'b1;
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		sel <= 1'b0;
		wr <= 1'b0;
		#1;
	endtask
	// read data taken after the edge that accepts the read
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sel <= 1'b1;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		sel <= 1'b0;
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule

//--- pmcr_regs_assertions.sv
/*
 * checker of register write and read effects at the bank's ports.
 * assumes it is bound to pmcr_regs by the bind below.
 */
`timescale 1ns/1ps
module pmcr_regs_chk (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       REG_SEL,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic [7:0] INPUT_CELL_BITS,
	input wire logic       LOGIC_CLOCK_INPUT,
	input wire logic       CELL_CLOCK,
	input wire logic       MODE_8051,
	input wire logic       CONTROL_INPUT_ZERO,
	input wire logic       ARRAY_CONTROL_ZERO,
	input wire logic [7:0] PAGE_BITS,
	input wire logic [7:0] OUTPUT_CELL_GROUP_A_BITS,
	input wire logic       SRAM_IN_PROGRAM_SPACE,
	input wire logic       PRIMARY_IN_DATA_SPACE,
	input wire logic       PORT_F_PERIPHERAL_MODE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire logic wr_v = REG_SEL && REG_WR;
	page_load_a: assert property (wr_v && REG_ADDR == 8'he0 |=> PAGE_BITS == $past(REG_WDATA))
		else $error("page bits not loaded");
	cell_hold_a: assert property (!(wr_v && REG_ADDR == 8'h20) |=> $stable(OUTPUT_CELL_GROUP_A_BITS))
		else $error("group a cells changed without write");
	cell_clock_a: assert property (wr_v && REG_ADDR == 8'hb0
		|=> CELL_CLOCK == (LOGIC_CLOCK_INPUT && !$past(REG_WDATA[5])))
		else $error("cell clock gating wrong");
	fetch_map_a: assert property (wr_v && REG_ADDR == 8'he2 && $past(RST_N)
		|=> SRAM_IN_PROGRAM_SPACE == (MODE_8051 && $past(REG_WDATA[0])))
		else $error("fetch space map wrong");
	data_map_a: assert property (wr_v && REG_ADDR == 8'he2 && $past(RST_N)
		|=> PRIMARY_IN_DATA_SPACE == (MODE_8051 && $past(REG_WDATA[4])))
		else $error("data space map wrong");
	periph_map_a: assert property (wr_v && REG_ADDR == 8'he2 && $past(RST_N)
		|=> PORT_F_PERIPHERAL_MODE == $past(REG_WDATA[7]))
		else $error("peripheral mode wrong");
	ctrl_gate_a: assert property (wr_v && REG_ADDR == 8'hb4
		|=> ARRAY_CONTROL_ZERO == (CONTROL_INPUT_ZERO && !$past(REG_WDATA[2])))
		else $error("control gating wrong");
	input_read_a: assert property (REG_SEL && REG_RD && REG_ADDR == 8'h0a
		|=> REG_RDATA == $past(INPUT_CELL_BITS))
		else $error("input cell read wrong");
endmodule
bind pmcr_regs pmcr_regs_chk chk_u (.*);

//--- pmcr_regs_tb_top.sv
/*
 * testbench of the register bank: bus accesses with expected values.
 * assumes the bus model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
module pmcr_regs_tb_top
	import pmcr_pkg::*;
;
	logic       CLK, RST_N, POWER_ON_RST_N, SECURITY_SET, MODE_8051, MODE_ALT_BUS;
	logic       LOGIC_CLOCK_INPUT, CONTROL_INPUT_ZERO, CONTROL_INPUT_ONE, CONTROL_INPUT_TWO;
	logic       ALE_INPUT, HIGH_WRITE_BYTE_ENABLE, TEST_PORT_ENABLED, AUTO_POWER_DOWN, w;
	logic       ARRAY_FAST_MODE, ARRAY_CLOCK, ARRAY_WAKE, CELL_CLOCK, ARRAY_CONTROL_ZERO;
	logic       ARRAY_CONTROL_ONE, ARRAY_CONTROL_TWO, ARRAY_ALE, ARRAY_HIGH_WRITE;
	logic       SRAM_IN_PROGRAM_SPACE, SECONDARY_IN_PROGRAM_SPACE, PRIMARY_IN_PROGRAM_SPACE;
	logic       SECONDARY_IN_DATA_SPACE, PRIMARY_IN_DATA_SPACE, PORT_F_PERIPHERAL_MODE;
	logic       REG_SEL, REG_WR, REG_RD;
	logic [3:0] SEC_SECTOR_PROT, CFG_SPACE_MAP, PORT_F_LOW, BUS_HIGH;
	pmcr_byte_t REG_ADDR, REG_WDATA, REG_RDATA, INPUT_CELL_BITS, PRIM_SECTOR_PROT, ADDR_LOW, d;
	pmcr_byte_t OUTPUT_CELL_GROUP_A_BITS, OUTPUT_CELL_GROUP_B_BITS, PAGE_BITS, ARRAY_ADDR;
	int         n_fail = 0;
	int         total_checks = 0;
	pmcr_byte_t in_offs [3] = '{8'h0a, 8'h0b, 8'h1a};
	wire pmcr_byte_t map_o = {PORT_F_PERIPHERAL_MODE, 2'h0, PRIMARY_IN_DATA_SPACE,
		SECONDARY_IN_DATA_SPACE, PRIMARY_IN_PROGRAM_SPACE, SECONDARY_IN_PROGRAM_SPACE,
		SRAM_IN_PROGRAM_SPACE};
	wire pmcr_byte_t pw0_o = {2'h0, CELL_CLOCK, ARRAY_CLOCK, ARRAY_FAST_MODE, 1'b0,
		AUTO_POWER_DOWN, 1'b0};
	wire pmcr_byte_t pw2_o = {1'b0, ARRAY_HIGH_WRITE, ARRAY_ALE, ARRAY_CONTROL_TWO,
		ARRAY_CONTROL_ONE, ARRAY_CONTROL_ZERO, 2'h0};
	pmcr_regs dut_u (.*);
	pmcr_mcu_model mcu_u (.clk(CLK), .sel(REG_SEL), .wr(REG_WR), .rd(REG_RD),
		.addr(REG_ADDR), .wdata(REG_WDATA), .rdata(REG_RDATA));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	task automatic chk(input pmcr_byte_t got, input pmcr_byte_t exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input pmcr_byte_t a, input pmcr_byte_t exp);
		mcu_u.rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial begin
		{RST_N, POWER_ON_RST_N, MODE_ALT_BUS, w} = 4'h0;
		{SECURITY_SET, MODE_8051, LOGIC_CLOCK_INPUT} = 3'h7;
		{CONTROL_INPUT_ZERO, CONTROL_INPUT_ONE, CONTROL_INPUT_TWO} = 3'h7;
		{ALE_INPUT, HIGH_WRITE_BYTE_ENABLE} = 2'h3;
		INPUT_CELL_BITS = 8'ha5;
		PRIM_SECTOR_PROT = 8'h3c;
		SEC_SECTOR_PROT = 4'h9;
		CFG_SPACE_MAP = 4'ha;
		ADDR_LOW = 8'h96;
		PORT_F_LOW = 4'h3;
		BUS_HIGH = 4'hc;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		POWER_ON_RST_N <= 1'b1;
		@(posedge CLK);
		rd_chk(8'he2, 8'h14);
		chk(map_o, 8'h14);
		rd_chk(8'he0, 8'h00);
		rd_chk(8'h22, 8'h00);
		rd_chk(8'hb0, 8'h00);
		chk(pw0_o, 8'h38);
		chk(pw2_o, 8'h7c);
		chk(ARRAY_ADDR, 8'h96);
		$display("test reset done");
		foreach (in_offs[i]) rd_chk(in_offs[i], 8'ha5);
		rd_chk(8'hc0, 8'h3c);
		rd_chk(8'hc2, 8'h89);
		mcu_u.wr_reg(8'hc0, 8'hff);
		rd_chk(8'hc0, 8'h3c);
		rd_chk(8'hf0, 8'h34);
		rd_chk(8'hf1, 8'h02);
		rd_chk(8'h55, 8'h00);
		mcu_u.wr_reg(8'hc7, 8'hff);
		rd_chk(8'hc7, 8'h01);
		chk({7'h0, TEST_PORT_ENABLED}, 8'h01);
		$display("test status done");
		mcu_u.wr_reg(8'h22, 8'hf0);
		mcu_u.wr_reg(8'h20, 8'h5a);
		chk(OUTPUT_CELL_GROUP_A_BITS, 8'h0a);
		rd_chk(8'h20, 8'h0a);
		mcu_u.wr_reg(8'h23, 8'h0f);
		mcu_u.wr_reg(8'h21, 8'hff);
		chk(OUTPUT_CELL_GROUP_B_BITS, 8'hf0);
		mcu_u.wr_reg(8'he0, 8'hc3);
		chk(PAGE_BITS, 8'hc3);
		$display("test cells done");
		mcu_u.wr_reg(8'hb0, 8'hff);
		rd_chk(8'hb0, 8'h3a);
		chk(pw0_o, 8'h02);
		@(posedge CLK);
		RST_N <= 1'b0;
		@(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		rd_chk(8'hb0, 8'h3a);
		rd_chk(8'he0, 8'h00);
		mcu_u.wr_reg(8'hb0, 8'h08);
		@(posedge CLK);
		LOGIC_CLOCK_INPUT <= 1'b0;
		repeat (4) begin
			@(negedge CLK);
			w = w | ARRAY_WAKE;
		end
		chk({7'h0, w}, 8'h01);
		chk({7'h0, ARRAY_WAKE}, 8'h00);
		mcu_u.wr_reg(8'hb4, 8'hff);
		rd_chk(8'hb4, 8'h7d);
		chk(pw2_o, 8'h00);
		chk(ARRAY_ADDR, 8'h00);
		mcu_u.wr_reg(8'hb4, 8'h00);
		@(posedge CLK);
		MODE_ALT_BUS <= 1'b1;
		#1;
		chk(ARRAY_ADDR, 8'hc3);
		$display("test power done");
		mcu_u.wr_reg(8'he2, 8'hff);
		rd_chk(8'he2, 8'h9f);
		chk(map_o, 8'h9f);
		@(posedge CLK);
		MODE_8051 <= 1'b0;
		#1;
		chk(map_o, 8'h80);
		$display("test map done");
		stop_test;
	end
endmodule
